// ==== core/exct_defs.vh ====
// Purpose: Constants for the exception sequence timing model.
// Assumes: Totals in core clock periods, bus counts per sequence.
// Notes:   One table entry per kind: three totals and r/w/p counts.
`ifndef EXCT_DEFS_VH
`define EXCT_DEFS_VH

// Sequence kinds
`define EXCT_K_BKPT     4'h0
`define EXCT_K_INT_I    4'h1
`define EXCT_K_INT_M    4'h2
`define EXCT_K_RESET    4'h3
`define EXCT_K_STOP     4'h4
`define EXCT_K_TRACE    4'h5
`define EXCT_K_TRAP     4'h6
`define EXCT_K_CTRAP    4'h7
`define EXCT_K_CTRAP_WL 4'h8
`define EXCT_K_FLT_S    4'h9
`define EXCT_K_FLT_L    4'ha
`define EXCT_K_RTE_N    4'hb
`define EXCT_K_RTE_THR  4'hc
`define EXCT_K_RTE_COP  4'hd
`define EXCT_K_RTE_SF   4'he
`define EXCT_K_RTE_LF   4'hf

// Timing cases
`define EXCT_C_BEST  2'h0
`define EXCT_C_CACHE 2'h1
`define EXCT_C_WORST 2'h2

// Entry layout: best, cache, worst, reads, writes, worst prefetches
`define EXCT_E_W     42
`define EXCT_E_BEST  41:32
`define EXCT_E_CACHE 31:22
`define EXCT_E_WORST 21:12
`define EXCT_E_RD    11:7
`define EXCT_E_WR    6:2
`define EXCT_E_PF    1:0

// Table entries
`define EXCT_V_BKPT  {10'h009,10'h00a,10'h00a,5'h01,5'h00,2'h0}
`define EXCT_V_INT_I {10'h01a,10'h01a,10'h021,5'h02,5'h04,2'h2}
`define EXCT_V_INT_M {10'h029,10'h029,10'h030,5'h02,5'h08,2'h2}
`define EXCT_V_RESET {10'h206,10'h206,10'h207,5'h00,5'h00,2'h1}
`define EXCT_V_STOP  {10'h008,10'h008,10'h008,5'h00,5'h00,2'h0}
`define EXCT_V_TRACE {10'h019,10'h019,10'h020,5'h01,5'h05,2'h2}
`define EXCT_V_TRAP  {10'h014,10'h014,10'h01b,5'h01,5'h04,2'h2}
`define EXCT_V_CTRAP {10'h017,10'h019,10'h020,5'h01,5'h05,2'h2}
`define EXCT_V_CTWL  {10'h017,10'h019,10'h021,5'h01,5'h05,2'h3}
`define EXCT_V_FLT_S {10'h02a,10'h02b,10'h032,5'h01,5'h0a,2'h2}
`define EXCT_V_FLT_L {10'h04f,10'h04f,10'h056,5'h01,5'h18,2'h2}
`define EXCT_V_RTE_N {10'h014,10'h015,10'h018,5'h04,5'h00,2'h2}
`define EXCT_V_RTE_T {10'h00f,10'h010,10'h027,5'h04,5'h00,2'h0}
`define EXCT_V_RTE_C {10'h01f,10'h020,10'h021,5'h07,5'h00,2'h1}
`define EXCT_V_RTE_S {10'h02a,10'h02b,10'h02d,5'h0a,5'h00,2'h2}
`define EXCT_V_RTE_L {10'h05b,10'h05c,10'h05e,5'h18,5'h00,2'h2}

`endif

// ==== core/exct_lut.v ====
// Purpose: Timing lookup for one sequence kind and case.
// Assumes: Purely combinational, read by the sequencer.
// Notes:   Prefetches only occur in the worst case.
`include "exct_defs.vh"

module exct_lut (
   // Selection
   input  wire [3:0] i_kind,
   input  wire [1:0] i_case,
   // Timing answer
   output reg  [9:0] o_total,
   output reg  [4:0] o_nrd,
   output reg  [4:0] o_nwr,
   output reg  [1:0] o_npf
);

   reg [`EXCT_E_W-1:0] entry;

   // Kind to packed table entry
   always @* begin
      case (i_kind)
         `EXCT_K_BKPT:     entry = `EXCT_V_BKPT;
         `EXCT_K_INT_I:    entry = `EXCT_V_INT_I;
         `EXCT_K_INT_M:    entry = `EXCT_V_INT_M;
         `EXCT_K_RESET:    entry = `EXCT_V_RESET;
         `EXCT_K_STOP:     entry = `EXCT_V_STOP;
         `EXCT_K_TRACE:    entry = `EXCT_V_TRACE;
         `EXCT_K_TRAP:     entry = `EXCT_V_TRAP;
         `EXCT_K_CTRAP:    entry = `EXCT_V_CTRAP;
         `EXCT_K_CTRAP_WL: entry = `EXCT_V_CTWL;
         `EXCT_K_FLT_S:    entry = `EXCT_V_FLT_S;
         `EXCT_K_FLT_L:    entry = `EXCT_V_FLT_L;
         `EXCT_K_RTE_N:    entry = `EXCT_V_RTE_N;
         `EXCT_K_RTE_THR:  entry = `EXCT_V_RTE_T;
         `EXCT_K_RTE_COP:  entry = `EXCT_V_RTE_C;
         `EXCT_K_RTE_SF:   entry = `EXCT_V_RTE_S;
         default:          entry = `EXCT_V_RTE_L;
      endcase
   end

   // Case picks the total and the prefetch count
   always @* begin
      o_nrd = entry[`EXCT_E_RD];
      o_nwr = entry[`EXCT_E_WR];
      case (i_case)
         `EXCT_C_BEST: begin
            o_total = entry[`EXCT_E_BEST];
            o_npf   = 2'h0;
         end
         `EXCT_C_CACHE: begin
            o_total = entry[`EXCT_E_CACHE];
            o_npf   = 2'h0;
         end
         default: begin
            o_total = entry[`EXCT_E_WORST];
            o_npf   = entry[`EXCT_E_PF];
         end
      endcase
   end

endmodule

// ==== core/exct_cnt.v ====
// Purpose: Up counter with synchronous clear and count enable.
// Assumes: Clear wins over enable.
// Notes:   Wraps at its width; callers keep counts in range.
module exct_cnt #(
   parameter W = 10
) (
   // Clock and reset
   input  wire         i_mclk,
   input  wire         i_nrst,
   // Control
   input  wire         i_clr,
   input  wire         i_en,
   // Count
   output reg  [W-1:0] o_cnt
);

   // Counter register
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cnt <= {W{1'b0}};
      end else if (i_clr) begin
         o_cnt <= {W{1'b0}};
      end else if (i_en) begin
         o_cnt <= o_cnt + {{(W-1){1'b0}}, 1'b1};
      end
   end

endmodule

// ==== core/exct_seq.v ====
// Purpose: Cycle-exact exception sequencer timing model.
// Assumes: Requests synchronous to i_mclk; memory needs no handshake.
// Notes:   Bus strobes and status other than o_busy lag the internal state by one cycle.
`include "exct_defs.vh"

// Function
// - Bus cycles fall inside the sequence total
// - Interrupt stack entry 26 or 33 clocks
// - Master stack entry 41 or 48 clocks
// - Reset instruction 518 or 519 clocks
// - Trap and illegal kinds 20 or 27 clocks
// - Taken conditional trap 23, 25, 32 clocks
// - Short fault save 42, 43, 50 clocks
// - Long fault save 79 or 86 clocks
// - Short fault return 42, 43, 45 clocks
// - Long fault return 91, 92, 94 clocks
// - Throwaway return chains into next frame
// - No address calculation time is added
module exct_seq (
   // Clock and reset
   input  wire       i_mclk,
   input  wire       i_nrst,
   // Request
   input  wire       i_start,
   input  wire [3:0] i_kind,
   input  wire [3:0] i_frame2_kind,
   input  wire       i_pf_overlap,
   input  wire       i_icache_hit,
   // Bus cycle strobes
   output reg        o_rd,
   output reg        o_pf,
   output reg        o_wr,
   // Status
   output reg        o_busy,
   output reg        o_done,
   output reg        o_chained,
   output reg  [3:0] o_kind,
   output reg  [1:0] o_case,
   output reg  [9:0] o_total,
   output reg  [9:0] o_cycles,
   output reg  [4:0] o_rd_cnt,
   output reg  [4:0] o_pf_cnt,
   output reg  [4:0] o_wr_cnt
);

   // Sequencer states
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN  = 1'b1;

   reg        state;
   reg        next_state;
   reg  [3:0] kind;
   reg  [3:0] next_kind;
   reg  [3:0] kind2;
   reg  [1:0] sel_case;
   reg        chained;
   reg        next_chained;
   reg  [1:0] start_case;

   wire [9:0] tot;
   wire [4:0] nrd;
   wire [4:0] nwr;
   wire [1:0] npf;
   wire [9:0] k;
   wire [9:0] k_all;

   wire       run;
   wire       take;
   wire       frame_end;
   wire       chain_go;
   wire       frame_clr;
   wire [9:0] rd_end;
   wire [9:0] wr_end;
   wire [9:0] pf_start;
   wire       cyc_rd;
   wire       cyc_wr;
   wire       cyc_pf;

   // Request acceptance
   assign run  = (state == ST_RUN);
   assign take = (state == ST_IDLE) & i_start;

   // Case choice for a new request
   always @* begin
      if (i_pf_overlap) begin
         start_case = `EXCT_C_BEST;
      end else if (i_icache_hit) begin
         start_case = `EXCT_C_CACHE;
      end else begin
         start_case = `EXCT_C_WORST;
      end
   end

   // Timing of the frame in progress
   exct_lut u_lut (
      .i_kind  (kind),
      .i_case  (sel_case),
      .o_total (tot),
      .o_nrd   (nrd),
      .o_nwr   (nwr),
      .o_npf   (npf)
   );

   // Cycle index within the current frame
   exct_cnt #(
      .W (10)
   ) u_frame_cnt (
      .i_mclk (i_mclk),
      .i_nrst (i_nrst),
      .i_clr  (frame_clr),
      .i_en   (run),
      .o_cnt  (k)
   );

   // Cycles over the whole chain
   exct_cnt #(
      .W (10)
   ) u_chain_cnt (
      .i_mclk (i_mclk),
      .i_nrst (i_nrst),
      .i_clr  (take),
      .i_en   (run),
      .o_cnt  (k_all)
   );

   // Frame end is the last listed clock, nothing added
   assign frame_end = run & (k == tot - 10'h001);
   assign chain_go  = frame_end & (kind == `EXCT_K_RTE_THR) & ~chained;
   assign frame_clr = take | chain_go;

   // Bus cycle placement: reads, then writes, prefetches last
   assign rd_end   = {5'h00, nrd};
   assign wr_end   = {5'h00, nrd} + {5'h00, nwr};
   assign pf_start = tot - {8'h00, npf};
   assign cyc_rd   = run & (k < rd_end);
   assign cyc_wr   = run & (k >= rd_end) & (k < wr_end);
   assign cyc_pf   = run & (k >= pf_start);

   // Next state and frame selection
   always @* begin
      next_state   = state;
      next_kind    = kind;
      next_chained = chained;
      case (state)
         ST_IDLE: begin
            if (i_start) begin
               next_state   = ST_RUN;
               next_kind    = i_kind;
               next_chained = 1'b0;
            end
         end
         ST_RUN: begin
            if (chain_go) begin
               // Second frame starts with no gap
               next_kind    = kind2;
               next_chained = 1'b1;
            end else if (frame_end) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         state   <= ST_IDLE;
         kind    <= `EXCT_K_BKPT;
         chained <= 1'b0;
      end else begin
         state   <= next_state;
         kind    <= next_kind;
         chained <= next_chained;
      end
   end

   // Timing case latched at take, kept for both frames
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         sel_case <= `EXCT_C_BEST;
      end else if (take) begin
         sel_case <= start_case;
      end
   end

   // Second frame kind; a throwaway second frame becomes normal
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         kind2 <= `EXCT_K_RTE_N;
      end else if (take) begin
         if (i_frame2_kind == `EXCT_K_RTE_THR) begin
            kind2 <= `EXCT_K_RTE_N;
         end else begin
            kind2 <= i_frame2_kind;
         end
      end
   end

   // Read strobe, one cycle behind the index
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rd <= 1'b0;
      end else begin
         o_rd <= cyc_rd;
      end
   end

   // Write strobe, after the reads of the frame
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_wr <= 1'b0;
      end else begin
         o_wr <= cyc_wr;
      end
   end

   // Prefetch strobe, last cycles of a worst-case frame
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pf <= 1'b0;
      end else begin
         o_pf <= cyc_pf;
      end
   end

   // Busy follows the next state so a refused start is visible
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_busy <= 1'b0;
      end else begin
         o_busy <= next_state;
      end
   end

   // Done only at the end of the whole chain
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_done <= 1'b0;
      end else begin
         o_done <= frame_end & ~chain_go;
      end
   end

   // Frame kind and case seen with the strobes
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_kind <= `EXCT_K_BKPT;
         o_case <= `EXCT_C_BEST;
      end else if (run) begin
         o_kind <= kind;
         o_case <= sel_case;
      end
   end

   // Frame total and chain flag seen with the strobes
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_total   <= 10'h000;
         o_chained <= 1'b0;
      end else if (run) begin
         o_total   <= tot;
         o_chained <= chained;
      end
   end

   // Length of the last complete chain
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cycles <= 10'h000;
      end else if (frame_end & ~chain_go) begin
         o_cycles <= k_all + 10'h001;
      end
   end

   // Read tally over the chain
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rd_cnt <= 5'h00;
      end else if (take) begin
         o_rd_cnt <= 5'h00;
      end else if (cyc_rd) begin
         o_rd_cnt <= o_rd_cnt + 5'h01;
      end
   end

   // Write tally over the chain
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_wr_cnt <= 5'h00;
      end else if (take) begin
         o_wr_cnt <= 5'h00;
      end else if (cyc_wr) begin
         o_wr_cnt <= o_wr_cnt + 5'h01;
      end
   end

   // Prefetch tally over the chain
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pf_cnt <= 5'h00;
      end else if (take) begin
         o_pf_cnt <= 5'h00;
      end else if (cyc_pf) begin
         o_pf_cnt <= o_pf_cnt + 5'h01;
      end
   end

endmodule

// ==== verification/exct_seq_properties.sv ====
// Purpose: Port timing checks on the exception sequencer.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Helper counters rebuild totals and tallies from strobes.
module exct_seq_properties (
   // Clock and reset
   input wire logic       i_mclk,
   input wire logic       i_nrst,
   // Request
   input wire logic       i_start,
   input wire logic [3:0] i_kind,
   input wire logic       i_pf_overlap,
   input wire logic       i_icache_hit,
   // Watched outputs
   input wire logic       o_rd,
   input wire logic       o_pf,
   input wire logic       o_wr,
   input wire logic       o_busy,
   input wire logic       o_done,
   input wire logic [1:0] o_case,
   input wire logic [9:0] o_cycles,
   input wire logic [4:0] o_rd_cnt,
   input wire logic [4:0] o_pf_cnt,
   input wire logic [4:0] o_wr_cnt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       take;
   logic [1:0] pick;
   logic [1:0] case_q;
   logic [9:0] cyc;
   logic [4:0] n_rd, n_wr, n_pf;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);

   // Take when idle; case as the inputs choose it
   assign take = i_start && !o_busy;
   assign pick = i_pf_overlap ? 2'h0 : (i_icache_hit ? 2'h1 : 2'h2);

   // Cycles and strobes since the last take
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         cyc <= 10'h000;
         n_rd <= 5'h00;
         n_wr <= 5'h00;
         n_pf <= 5'h00;
         case_q <= 2'h0;
      end else if (take) begin
         cyc <= 10'h000;
         n_rd <= 5'h00;
         n_wr <= 5'h00;
         n_pf <= 5'h00;
         case_q <= pick;
      end else begin
         cyc <= cyc + 10'h001;
         n_rd <= n_rd + {4'h0, o_rd};
         n_wr <= n_wr + {4'h0, o_wr};
         n_pf <= n_pf + {4'h0, o_pf};
      end
   end

   sequence s_take(logic [3:0] k, logic [1:0] c);
      take && i_kind == k && pick == c;
   endsequence

   sequence s_int_i_bus;
      o_rd [*2] ##1 o_wr [*4];
   endsequence

   strobe_in_seq_a: assert property ((o_rd || o_wr || o_pf) |->
      (o_busy || o_done)) else $error("bus strobe outside sequence");
   cycle_sum_a: assert property (o_done |-> o_cycles == cyc)
      else $error("cycle total differs from elapsed cycles");
   tally_sum_a: assert property (o_done |->
      o_rd_cnt == n_rd + {4'h0, o_rd} && o_wr_cnt == n_wr + {4'h0, o_wr}
      && o_pf_cnt == n_pf + {4'h0, o_pf}) else $error("tally mismatch");
   case_pick_a: assert property (o_done |-> o_case == case_q)
      else $error("timing case not as chosen at take");
   int_i_best_a: assert property (s_take(4'h1, 2'h0) |->
      ##2 s_int_i_bus ##20 o_done) else $error("interrupt entry timing");
   int_m_worst_a: assert property (s_take(4'h2, 2'h2) |->
      ##48 o_pf ##1 (o_pf && o_done)) else $error("master stack timing");
   reset_insn_a: assert property (s_take(4'h3, 2'h0) |->
      ##[519:519] (o_done && o_rd_cnt == 5'h00 && o_wr_cnt == 5'h00))
      else $error("reset instruction timing");
   trap_worst_a: assert property (s_take(4'h6, 2'h2) |->
      ##27 !o_done ##1 (o_done && o_pf_cnt == 5'h02))
      else $error("trap worst case timing");
   ctrap_cache_a: assert property (s_take(4'h7, 2'h1) |->
      ##26 (o_done && o_wr_cnt == 5'h05)) else $error("taken trap timing");
   fault_long_a: assert property (s_take(4'ha, 2'h0) |->
      ##80 o_done) else $error("long fault save timing");
endmodule

bind exct_seq exct_seq_properties chk (.i_mclk, .i_nrst, .i_start,
   .i_kind, .i_pf_overlap, .i_icache_hit, .o_rd, .o_pf, .o_wr, .o_busy,
   .o_done, .o_case, .o_cycles, .o_rd_cnt, .o_pf_cnt, .o_wr_cnt);

// ==== verification/exct_mem.sv ====
// Purpose: Frame memory on the far side of the bus strobes.
// Assumes: No acknowledge; one strobe is one bus cycle.
// Notes:   Tallies each access kind until cleared.
module exct_mem (
   input  wire logic i_mclk,
   input  wire logic i_clr,
   input  wire logic i_rd,
   input  wire logic i_wr,
   input  wire logic i_pf,
   output int        o_nrd,
   output int        o_nwr,
   output int        o_npf
);
   timeunit 1ns;
   timeprecision 100ps;
   // Count every bus cycle the sequencer issues
   always @(posedge i_mclk) begin
      o_nrd <= i_clr ? 0 : o_nrd + int'(i_rd);
      o_nwr <= i_clr ? 0 : o_nwr + int'(i_wr);
      o_npf <= i_clr ? 0 : o_npf + int'(i_pf);
   end
endmodule

// ==== verification/exct_seq_bench.sv ====
// Purpose: Self-checking bench for the exception sequencer.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes:   Expected totals are the table figures per case, summed over both frames of a chain.
module exct_seq_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic       i_mclk = 1'b0;
   logic       i_nrst = 1'b0;
   logic       i_start = 1'b0;
   logic [3:0] i_kind = 4'h0;
   logic [3:0] i_frame2_kind = 4'h0;
   logic       i_pf_overlap = 1'b0;
   logic       i_icache_hit = 1'b0;
   logic       clr = 1'b0;
   logic       poke = 1'b0;
   wire        o_rd, o_pf, o_wr, o_busy, o_done, o_chained;
   wire  [3:0] o_kind;
   wire  [1:0] o_case;
   wire  [9:0] o_total, o_cycles;
   wire  [4:0] o_rd_cnt, o_pf_cnt, o_wr_cnt;
   int         nrd, nwr, npf;
   int         bad_count = 0;
   int         n_checks = 0;

   exct_seq uut (.i_mclk, .i_nrst, .i_start, .i_kind, .i_frame2_kind,
      .i_pf_overlap, .i_icache_hit, .o_rd, .o_pf, .o_wr, .o_busy, .o_done,
      .o_chained, .o_kind, .o_case, .o_total, .o_cycles, .o_rd_cnt,
      .o_pf_cnt, .o_wr_cnt);
   exct_mem mem (.i_mclk, .i_clr(clr), .i_rd(o_rd), .i_wr(o_wr),
      .i_pf(o_pf), .o_nrd(nrd), .o_nwr(nwr), .o_npf(npf));

   // 125 MHz clock
   always #4 i_mclk = ~i_mclk;

   task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      n_checks++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
         bad_count++;
      end
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One sequence: take, wait for done, compare total and bus mix
   task do_seq(input logic [3:0] k, k2, input logic [1:0] cs,
               input logic [9:0] n, r, w, p);
      int         cyc;
      logic [3:0] k_show;
      logic [9:0] t_show;
      i_start = 1'b1;
      i_kind = k;
      i_frame2_kind = k2;
      i_pf_overlap = (cs == 2'h0);
      i_icache_hit = (cs == 2'h1);
      clr = 1'b1;
      @(posedge i_mclk);
      #1;
      i_start = 1'b0;
      clr = 1'b0;
      cyc = 0;
      chk("o_busy at take", 10'd1, {9'd0, o_busy});
      while (o_done !== 1'b1 && cyc < 1100) begin
         @(posedge i_mclk);
         #1;
         cyc++;
         i_start = poke && cyc == 5;
         i_kind = (poke && cyc == 5) ? 4'h2 : k;
      end
      // Frame showing at the end: the second one of a chain
      k_show = (k != 4'hc) ? k : ((k2 == 4'hc) ? 4'hb : k2);
      t_show = (k != 4'hc) ? n : n - ((cs == 2'h0) ? 10'd15 :
               ((cs == 2'h1) ? 10'd16 : 10'd39));
      chk("total", n, cyc[9:0]);
      chk("o_cycles", n, o_cycles);
      chk("o_busy at done", 10'd0, {9'd0, o_busy});
      chk("o_kind", {6'd0, k_show}, {6'd0, o_kind});
      chk("o_case", {8'd0, cs}, {8'd0, o_case});
      chk("o_total", t_show, o_total);
      chk("o_chained", {9'd0, k == 4'hc}, {9'd0, o_chained});
      chk("o_rd_cnt", r, {5'd0, o_rd_cnt});
      chk("o_wr_cnt", w, {5'd0, o_wr_cnt});
      chk("o_pf_cnt", p, {5'd0, o_pf_cnt});
      @(posedge i_mclk);
      #1;
      chk("o_done one cycle", 10'd0, {9'd0, o_done});
      chk("reads", r, nrd[9:0]);
      chk("writes", w, nwr[9:0]);
      chk("prefetches", p, npf[9:0]);
   endtask

   task t_interrupts;
      do_seq(4'h1, 4'h0, 2'h0, 10'd26, 10'd2, 10'd4, 10'd0);
      do_seq(4'h1, 4'h0, 2'h2, 10'd33, 10'd2, 10'd4, 10'd2);
      do_seq(4'h2, 4'h0, 2'h1, 10'd41, 10'd2, 10'd8, 10'd0);
      do_seq(4'h2, 4'h0, 2'h2, 10'd48, 10'd2, 10'd8, 10'd2);
   endtask

   task t_reset_insn;
      do_seq(4'h3, 4'h0, 2'h0, 10'd518, 10'd0, 10'd0, 10'd0);
      do_seq(4'h3, 4'h0, 2'h2, 10'd519, 10'd0, 10'd0, 10'd1);
   endtask

   task t_traps;
      do_seq(4'h6, 4'h0, 2'h1, 10'd20, 10'd1, 10'd4, 10'd0);
      do_seq(4'h6, 4'h0, 2'h2, 10'd27, 10'd1, 10'd4, 10'd2);
      do_seq(4'h7, 4'h0, 2'h0, 10'd23, 10'd1, 10'd5, 10'd0);
      do_seq(4'h7, 4'h0, 2'h1, 10'd25, 10'd1, 10'd5, 10'd0);
      do_seq(4'h8, 4'h0, 2'h1, 10'd25, 10'd1, 10'd5, 10'd0);
      do_seq(4'h7, 4'h0, 2'h2, 10'd32, 10'd1, 10'd5, 10'd2);
      do_seq(4'h8, 4'h0, 2'h2, 10'd33, 10'd1, 10'd5, 10'd3);
   endtask

   task t_fault_save;
      do_seq(4'h9, 4'h0, 2'h0, 10'd42, 10'd1, 10'd10, 10'd0);
      do_seq(4'h9, 4'h0, 2'h1, 10'd43, 10'd1, 10'd10, 10'd0);
      do_seq(4'h9, 4'h0, 2'h2, 10'd50, 10'd1, 10'd10, 10'd2);
      do_seq(4'ha, 4'h0, 2'h0, 10'd79, 10'd1, 10'd24, 10'd0);
      do_seq(4'ha, 4'h0, 2'h2, 10'd86, 10'd1, 10'd24, 10'd2);
   endtask

   task t_fault_ret;
      do_seq(4'he, 4'h0, 2'h0, 10'd42, 10'd10, 10'd0, 10'd0);
      do_seq(4'he, 4'h0, 2'h1, 10'd43, 10'd10, 10'd0, 10'd0);
      do_seq(4'he, 4'h0, 2'h2, 10'd45, 10'd10, 10'd0, 10'd2);
      do_seq(4'hf, 4'h0, 2'h0, 10'd91, 10'd24, 10'd0, 10'd0);
      do_seq(4'hf, 4'h0, 2'h1, 10'd92, 10'd24, 10'd0, 10'd0);
      do_seq(4'hf, 4'h0, 2'h2, 10'd94, 10'd24, 10'd0, 10'd2);
   endtask

   // Throwaway then a fault or normal frame: totals add up across both
   task t_throwaway;
      do_seq(4'hc, 4'he, 2'h1, 10'd59, 10'd14, 10'd0, 10'd0);
      do_seq(4'hc, 4'hf, 2'h2, 10'd133, 10'd28, 10'd0, 10'd2);
      do_seq(4'hc, 4'hc, 2'h0, 10'd35, 10'd8, 10'd0, 10'd0);
   endtask

   // Table kinds outside the numbered rules
   task t_misc;
      do_seq(4'h0, 4'h0, 2'h0, 10'd9, 10'd1, 10'd0, 10'd0);
      do_seq(4'h0, 4'h0, 2'h2, 10'd10, 10'd1, 10'd0, 10'd0);
      do_seq(4'h4, 4'h0, 2'h1, 10'd8, 10'd0, 10'd0, 10'd0);
      do_seq(4'h5, 4'h0, 2'h2, 10'd32, 10'd1, 10'd5, 10'd2);
      do_seq(4'hb, 4'h0, 2'h1, 10'd21, 10'd4, 10'd0, 10'd0);
      do_seq(4'hd, 4'h0, 2'h2, 10'd33, 10'd7, 10'd0, 10'd1);
   endtask

   // Reset in mid-sequence abandons it and clears the status
   task t_reset_mid;
      i_start = 1'b1;
      i_kind = 4'hb;
      @(posedge i_mclk);
      #1;
      i_start = 1'b0;
      repeat (5) @(posedge i_mclk);
      #1;
      i_nrst = 1'b0;
      #1;
      chk("reset o_busy", 10'd0, {9'd0, o_busy});
      chk("reset o_cycles", 10'd0, o_cycles);
      chk("reset o_rd_cnt", 10'd0, {5'd0, o_rd_cnt});
      repeat (2) @(posedge i_mclk);
      #1;
      i_nrst = 1'b1;
      do_seq(4'h1, 4'h0, 2'h0, 10'd26, 10'd2, 10'd4, 10'd0);
   endtask

   // A start in mid-run must leave the running sequence untouched
   task t_refuse;
      poke = 1'b1;
      do_seq(4'h6, 4'h0, 2'h0, 10'd20, 10'd1, 10'd4, 10'd0);
      poke = 1'b0;
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge i_mclk);
      #1;
      i_nrst = 1'b1;
      t_interrupts();
      t_reset_insn();
      t_traps();
      t_fault_save();
      t_fault_ret();
      t_throwaway();
      t_refuse();
      t_misc();
      t_reset_mid();
      end_sim();
   end

   // Watchdog against a hang
   initial begin
      #100000;
      bad_count++;
      end_sim();
   end
endmodule
